// File: src/apdu_pkg.sv
package apdu_pkg;
  localparam logic [3:0]  CLA_HI_BASIC  = 4'h0;
  localparam logic [3:0]  CLA_HI_PROP   = 4'h8;
  localparam logic [7:0]  INS_SELECT    = 8'hA4;
  localparam logic [7:0]  INS_STATUS    = 8'hF2;
  localparam logic [7:0]  INS_READ_BIN  = 8'hB0;
  localparam logic [7:0]  INS_READ_REC  = 8'hB2;
  localparam logic [7:0]  INS_VERIFY    = 8'h20;
  localparam logic [7:0]  INS_UNBLOCK   = 8'h2C;
  localparam logic [7:0]  INS_GET_RSP   = 8'hC0;
  localparam logic [7:0]  P1_BY_ID      = 8'h00;
  localparam logic [7:0]  P1_BY_NAME    = 8'h04;
  localparam logic [7:0]  P2_FCP        = 8'h04;
  localparam logic [7:0]  P2_NO_DATA    = 8'h0C;
  localparam logic [7:0]  P2_STATUS_APP = 8'h00;
  localparam logic [2:0]  REC_NEXT      = 3'h2;
  localparam logic [2:0]  REC_PREV      = 3'h3;
  localparam logic [2:0]  REC_ABS       = 3'h4;
  localparam int          SFI_BIT       = 7;
  localparam logic [15:0] FID_ROOT      = 16'h3F00;
  localparam logic [15:0] SW_OK         = 16'h9000;
  localparam logic [15:0] SW_WRONG_LEN  = 16'h6700;
  localparam logic [15:0] SW_WRONG_P1P2 = 16'h6B00;
  localparam logic [15:0] SW_REC_NF     = 16'h6A83;
  localparam logic [15:0] SW_FILE_NF    = 16'h6A82;
  localparam logic [15:0] SW_INCOMPAT   = 16'h6981;
  localparam logic [15:0] SW_SEC_NS     = 16'h6982;
  localparam logic [15:0] SW_BLOCKED    = 16'h6983;
  localparam logic [15:0] SW_NO_EF      = 16'h6986;
  localparam logic [15:0] SW_INS_NS     = 16'h6D00;
  localparam logic [15:0] SW_CLA_NS     = 16'h6E00;
  localparam logic [15:0] SW_TECH       = 16'h6F00;
  localparam logic [15:0] SW_LCH_NS     = 16'h6881;
  localparam logic [15:0] SW_SM_NS      = 16'h6882;
  localparam logic [7:0]  SW1_VERIFY    = 8'h63;
  localparam logic [3:0]  SW2_CNT_HI    = 4'hC;
  localparam int          P3_IDX        = 4;
  localparam int          DATA_IDX      = 5;
  localparam int          BUF_DEPTH     = 8;
  localparam logic [7:0]  LC_FID        = 8'h02;
  localparam logic [8:0]  FCP_LEN       = 9'h010;
  localparam logic [8:0]  LE_ZERO_LEN   = 9'h100;
  localparam logic [1:0]  RETRY_MAX     = 2'h3;
  localparam logic [7:0]  FILL_BYTE     = 8'hFF;

  typedef enum logic [1:0] {FK_NONE, FK_DF, FK_TRANS, FK_REC} file_kind_t;
endpackage : apdu_pkg

`timescale 1ns/10ps
`default_nettype none
module rsp_serializer
  import apdu_pkg::*;
(
  input  wire logic       sys_clk,
  input  wire logic       reset,
  input  wire logic       start,
  input  wire logic [8:0] data_len,
  input  wire logic [15:0] sw,
  input  wire logic       rsp_ready,
  output logic            rsp_valid,
  output logic [7:0]      rsp_byte,
  output logic            rsp_last,
  output logic            busy
);
  typedef enum logic [1:0] {S_IDLE, S_DATA, S_SW1, S_SW2} ser_state_t;
  ser_state_t  st_q, st_d;
  logic [8:0]  cnt_q, cnt_d;
  logic [15:0] sw_q, sw_d;
  logic        valid_q, valid_d, last_q, last_d;
  logic [7:0]  byte_q, byte_d;

  always_comb begin
    st_d    = st_q;
    cnt_d   = cnt_q;
    sw_d    = sw_q;
    valid_d = valid_q;
    last_d  = last_q;
    byte_d  = byte_q;
    case (st_q)
      S_IDLE: begin
        if (start) begin
          cnt_d   = data_len;
          sw_d    = sw;
          valid_d = 1'b1;
          if (data_len != 9'h000) begin
            st_d   = S_DATA;
            byte_d = FILL_BYTE;
          end else begin
            st_d   = S_SW1;
            byte_d = sw[15:8];
          end
        end
      end
      S_DATA: begin
        if (rsp_ready) begin
          if (cnt_q == 9'h001) begin
            st_d   = S_SW1;
            byte_d = sw_q[15:8]; // Data first, then SW1
          end else begin
            cnt_d = cnt_q - 9'h001;
          end
        end
      end
      S_SW1: begin
        if (rsp_ready) begin
          st_d   = S_SW2;
          byte_d = sw_q[7:0]; // SW2 always follows SW1
          last_d = 1'b1;
        end
      end
      S_SW2: begin
        if (rsp_ready) begin
          st_d    = S_IDLE;
          valid_d = 1'b0;
          last_d  = 1'b0;
        end
      end
      default: st_d = S_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      st_q    <= S_IDLE;
      cnt_q   <= 9'h000;
      sw_q    <= 16'h0000;
      valid_q <= 1'b0;
      last_q  <= 1'b0;
      byte_q  <= 8'h00;
    end else begin
      st_q    <= st_d;
      cnt_q   <= cnt_d;
      sw_q    <= sw_d;
      valid_q <= valid_d;
      last_q  <= last_d;
      byte_q  <= byte_d;
    end
  end

  assign rsp_valid = valid_q;
  assign rsp_byte  = byte_q;
  assign rsp_last  = last_q;
  assign busy      = (st_q != S_IDLE);
endmodule : rsp_serializer
`default_nettype wire

// File: src/card_apdu_status_responder.sv
`timescale 1ns/10ps
`default_nettype none
module card_apdu_status_responder
  import apdu_pkg::*;
#(
  parameter logic [15:0] TRANS_FID  = 16'h6F07,
  parameter logic [15:0] TRANS_FID2 = 16'h6F7E,
  parameter logic [15:0] REC_FID    = 16'h6FB7,
  parameter logic [8:0]  TRANS_SIZE = 9'h009,
  parameter logic [7:0]  REC_COUNT  = 8'h01,
  parameter logic [8:0]  REC_LEN    = 9'h004,
  parameter logic [63:0] PIN_CODE   = 64'h31323334FFFFFFFF,
  parameter logic [63:0] PUK_CODE   = 64'h3132333435363738
)(
  input  wire logic       sys_clk,
  input  wire logic       reset,
  input  wire logic       cmd_valid,
  input  wire logic [7:0] cmd_byte,
  input  wire logic       cmd_last,
  output logic            cmd_ready,
  input  wire logic       rsp_ready,
  output logic            rsp_valid,
  output logic [7:0]      rsp_byte,
  output logic            rsp_last,
  output logic            code_blocked
);
  import apdu_pkg::*;

  typedef enum logic [1:0] {M_COLLECT, M_EXEC, M_SEND} main_state_t;

  function automatic logic [8:0] le_len(input logic [7:0] le);
    le_len = (le == 8'h00) ? LE_ZERO_LEN : {1'b0, le};
  endfunction : le_len

  function automatic logic [8:0] min9(input logic [8:0] a, input logic [8:0] b);
    min9 = (a < b) ? a : b;
  endfunction : min9

  function automatic logic [8:0] sel_len(input logic [7:0] p2v, input logic [8:0] lev);
    sel_len = (p2v == P2_FCP) ? min9(FCP_LEN, lev) : 9'h000;
  endfunction : sel_len

  main_state_t st_q, st_d;
  logic [7:0]  hdr_q [0:P3_IDX];
  logic [7:0]  hdr_d [0:P3_IDX];
  logic [7:0]  buf_q [0:BUF_DEPTH-1];
  logic [7:0]  buf_d [0:BUF_DEPTH-1];
  logic [8:0]  n_q, n_d;
  logic [7:0]  lastb_q, lastb_d;
  logic        ready_q, ready_d;
  file_kind_t  kind_q, kind_d;
  logic [7:0]  rec_q, rec_d;
  logic [1:0]  tries_q, tries_d;
  logic        blk_q, blk_d;
  logic        start;
  logic [8:0]  len;
  logic [15:0] sw;
  logic        busy;

  logic [7:0]  cla, ins, p1, p2, p3;
  logic [8:0]  lc;
  logic [8:0]  le;
  logic [15:0] fid;
  logic [63:0] code;
  logic [8:0]  offs;

  assign cla  = hdr_q[0];
  assign ins  = hdr_q[1];
  assign p1   = hdr_q[2];
  assign p2   = hdr_q[3];
  assign p3   = hdr_q[P3_IDX];
  assign fid  = {buf_q[0], buf_q[1]};
  assign code = {buf_q[0], buf_q[1], buf_q[2], buf_q[3],
                 buf_q[4], buf_q[5], buf_q[6], buf_q[7]};
  assign offs = {p1[0], p2};

  // Case 1/2 when no body follows P3, otherwise Lc then optional Le
  always_comb begin
    if (n_q <= 9'(DATA_IDX)) begin
      lc = 9'h000;
      le = (n_q == 9'(DATA_IDX)) ? le_len(p3) : 9'h000;
    end else begin
      lc = {1'b0, p3};
      le = (n_q == {1'b0, p3} + 9'(DATA_IDX + 1)) ? le_len(lastb_q) : 9'h000;
    end
  end

  always_comb begin
    st_d    = st_q;
    hdr_d   = hdr_q;
    buf_d   = buf_q;
    n_d     = n_q;
    lastb_d = lastb_q;
    ready_d = ready_q;
    kind_d  = kind_q;
    rec_d   = rec_q;
    tries_d = tries_q;
    blk_d   = blk_q;
    start   = 1'b0;
    len     = 9'h000;
    sw      = SW_OK; // Default ending for correct execution
    case (st_q)
      M_COLLECT: begin
        if (cmd_valid && ready_q) begin
          lastb_d = cmd_byte;
          if (n_q <= 9'(P3_IDX)) begin
            hdr_d[n_q[2:0]] = cmd_byte;
          end else if (n_q < 9'(DATA_IDX + BUF_DEPTH)) begin
            buf_d[3'(n_q - 9'(DATA_IDX))] = cmd_byte;
          end
          // Long bodies are counted but only the first bytes are kept
          if (n_q != 9'h1FF) begin
            n_d = n_q + 9'h001;
          end
          if (cmd_last) begin
            st_d    = M_EXEC;
            ready_d = 1'b0;
          end
        end
      end
      M_EXEC: begin
        start = 1'b1;
        st_d  = M_SEND;
        if (n_q < 9'(P3_IDX)) begin
          sw = SW_WRONG_LEN; // Header shorter than four bytes
        end else if (cla[7:4] != CLA_HI_BASIC && cla[7:4] != CLA_HI_PROP) begin
          sw = SW_CLA_NS;
        end else if (cla[3:2] != 2'b00) begin
          sw = SW_SM_NS;
        end else if (cla[1:0] != 2'b00) begin
          sw = SW_LCH_NS;
        end else begin
          // Both accepted class families share the decoder
          case (ins)
            INS_SELECT: begin
              if (p1 == P1_BY_NAME) begin
                kind_d = FK_DF;
                len    = sel_len(p2, le);
              end else if (lc != {1'b0, LC_FID}) begin
                sw = SW_WRONG_LEN;
              end else if (fid == FID_ROOT) begin
                kind_d = FK_DF;
                rec_d  = 8'h00;
                len    = sel_len(p2, le);
              end else if (fid == TRANS_FID || fid == TRANS_FID2) begin
                kind_d = FK_TRANS;
                len    = sel_len(p2, le);
              end else if (fid == REC_FID) begin
                kind_d = FK_REC;
                rec_d  = 8'h00;
                len    = sel_len(p2, le);
              end else begin
                sw = SW_FILE_NF; // Selection left unchanged
              end
            end
            INS_STATUS: begin
              // P2 0C gives status only, with or without a length byte
              len = (p2 == P2_NO_DATA) ? 9'h000 : min9(FCP_LEN, le);
            end
            INS_READ_BIN: begin
              if (p1[SFI_BIT]) begin
                len = 9'h000; // Short identifier reads not modelled here
                sw  = SW_NO_EF;
              end else if (kind_q == FK_NONE || kind_q == FK_DF) begin
                sw = SW_NO_EF;
              end else if (kind_q == FK_REC) begin
                sw = SW_INCOMPAT;
              end else if (offs >= TRANS_SIZE) begin
                sw = SW_WRONG_P1P2;
              end else begin
                len = min9(le, TRANS_SIZE - offs);
              end
            end
            INS_READ_REC: begin
              if (kind_q == FK_NONE || kind_q == FK_DF) begin
                sw = SW_NO_EF;
              end else if (kind_q == FK_TRANS) begin
                sw = SW_INCOMPAT;
              end else begin
                case (p2[2:0])
                  REC_NEXT: begin
                    if (rec_q >= REC_COUNT) begin
                      sw = SW_REC_NF;
                    end else begin
                      rec_d = rec_q + 8'h01;
                      len   = REC_LEN;
                    end
                  end
                  REC_PREV: begin
                    if (rec_q <= 8'h01) begin
                      sw = SW_REC_NF;
                    end else begin
                      rec_d = rec_q - 8'h01;
                      len   = REC_LEN;
                    end
                  end
                  REC_ABS: begin
                    if (p1 == 8'h00 || p1 > REC_COUNT) begin
                      sw = SW_REC_NF;
                    end else begin
                      len = REC_LEN;
                    end
                  end
                  default: sw = SW_WRONG_P1P2;
                endcase
              end
            end
            INS_VERIFY: begin
              if (blk_q) begin
                sw = SW_BLOCKED;
              end else if (code == PIN_CODE) begin
                tries_d = RETRY_MAX;
              end else begin
                tries_d = tries_q - 2'h1;
                blk_d   = (tries_q == 2'h1);
                sw      = {SW1_VERIFY, SW2_CNT_HI, 2'b00, tries_q - 2'h1};
              end
            end
            INS_UNBLOCK: begin
              if (code == PUK_CODE) begin
                tries_d = RETRY_MAX;
                blk_d   = 1'b0;
              end else begin
                sw = SW_SEC_NS;
              end
            end
            // Data is always returned inline, so nothing is ever pending
            INS_GET_RSP: sw = SW_TECH;
            default:     sw = SW_INS_NS;
          endcase
        end
      end
      M_SEND: begin
        if (!busy) begin
          st_d    = M_COLLECT;
          n_d     = 9'h000;
          ready_d = 1'b1;
        end
      end
      default: st_d = M_COLLECT;
    endcase
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      st_q    <= M_COLLECT;
      n_q     <= 9'h000;
      lastb_q <= 8'h00;
      ready_q <= 1'b1;
      kind_q  <= FK_NONE;
      rec_q   <= 8'h00;
      tries_q <= RETRY_MAX;
      blk_q   <= 1'b0;
      for (int i = 0; i <= P3_IDX; i++) begin
        hdr_q[i] <= 8'h00;
      end
      for (int i = 0; i < BUF_DEPTH; i++) begin
        buf_q[i] <= 8'h00;
      end
    end else begin
      st_q    <= st_d;
      n_q     <= n_d;
      lastb_q <= lastb_d;
      ready_q <= ready_d;
      kind_q  <= kind_d;
      rec_q   <= rec_d;
      tries_q <= tries_d;
      blk_q   <= blk_d;
      hdr_q   <= hdr_d;
      buf_q   <= buf_d;
    end
  end

  rsp_serializer u_ser (
    .sys_clk   (sys_clk),
    .reset     (reset),
    .start     (start),
    .data_len  (len),
    .sw        (sw),
    .rsp_ready (rsp_ready),
    .rsp_valid (rsp_valid),
    .rsp_byte  (rsp_byte),
    .rsp_last  (rsp_last),
    .busy      (busy)
  );

  assign cmd_ready    = ready_q;
  assign code_blocked = blk_q;
endmodule : card_apdu_status_responder
`default_nettype wire

// File: testbench/apdu_resp_props.sv
`timescale 1ns/10ps
`default_nettype none
module apdu_resp_props
  import apdu_pkg::*;
(
  input wire logic       sys_clk,
  input wire logic       reset,
  input wire logic       cmd_valid,
  input wire logic [7:0] cmd_byte,
  input wire logic       cmd_last,
  input wire logic       cmd_ready,
  input wire logic       rsp_ready,
  input wire logic       rsp_valid,
  input wire logic [7:0] rsp_byte,
  input wire logic       rsp_last,
  input wire logic       code_blocked
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);
  wire logic end_cmd = cmd_valid && cmd_ready && cmd_last;
  wire logic sw2_took = rsp_valid && rsp_ready && rsp_last;
  a_ready_drops: assert property (end_cmd |=> !cmd_ready)
    else $error("ready high after last byte");
  a_answer_delay: assert property (end_cmd |=> !rsp_valid ##1 rsp_valid)
    else $error("answer not two edges after command");
  a_rsp_holds: assert property (rsp_valid && !rsp_ready |=> rsp_valid && $stable(rsp_byte))
    else $error("response byte dropped before taken");
  a_last_ends: assert property (sw2_took |=> !rsp_valid)
    else $error("response runs past status pair");
  a_no_overlap: assert property (rsp_valid |-> !cmd_ready)
    else $error("command taken while answering");
  a_ready_back: assert property (sw2_took |-> ##[1:2] cmd_ready)
    else $error("ready not back after status pair");
  a_block_answer: assert property ($rose(code_blocked) |-> ##[0:3] (rsp_valid && rsp_byte == SW1_VERIFY))
    else $error("blocked without countdown answer");
  a_block_steady: assert property (!$stable(code_blocked) |-> !cmd_ready)
    else $error("blocked flag moved outside a command");
endmodule : apdu_resp_props
`default_nettype wire

// File: testbench/apdu_terminal.sv
`timescale 1ns/10ps
`default_nettype none
module apdu_terminal (
  input  wire logic       sys_clk,
  input  wire logic [7:0] rnd,
  input  wire logic       cmd_ready,
  input  wire logic       rsp_valid,
  input  wire logic [7:0] rsp_byte,
  input  wire logic       rsp_last,
  output logic            cmd_valid,
  output logic [7:0]      cmd_byte,
  output logic            cmd_last,
  output logic            rsp_ready
);
  logic [7:0] got[$];
  logic       fin;
  initial begin
    cmd_valid = 1'b0;
    cmd_byte = 8'h00;
    cmd_last = 1'b0;
    rsp_ready = 1'b0;
  end
  // Header first, body and length after, last byte flagged
  task automatic xfer(input logic [7:0] c[$]);
    got = {};
    fin = 1'b0;
    foreach (c[i]) begin
      cmd_byte = c[i];
      cmd_last = (i == c.size() - 1);
      cmd_valid = 1'b1;
      do @(posedge sys_clk); while (cmd_ready !== 1'b1);
      #1;
      if (rnd[0] || cmd_last) begin
        // Released bus shows inverted data, not a stale byte
        cmd_valid = 1'b0;
        cmd_byte = ~cmd_byte;
        cmd_last = 1'b0;
        @(posedge sys_clk);
        #1;
      end
    end
    for (int t = 0; t < 500 && !fin; t++) @(posedge sys_clk);
    #1;
  endtask : xfer
  // Bytes gathered in arrival order, random stalls
  always @(posedge sys_clk) begin
    if (rsp_valid === 1'b1 && rsp_ready === 1'b1) got.push_back(rsp_byte);
    if (rsp_valid === 1'b1 && rsp_ready === 1'b1 && rsp_last === 1'b1) fin = 1'b1;
    #1 rsp_ready = rnd[1] | rnd[2];
  end
endmodule : apdu_terminal
`default_nettype wire

// File: testbench/tb.sv
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b, m) begin compares++; if ((a) !== (b)) begin failures++; \
  $display("CHECK FAILED %0t %s", $time, m); end end
module tb;
  import apdu_pkg::*;
  localparam logic [63:0] PIN = 64'h31323334FFFFFFFF;
  localparam logic [63:0] PUK = 64'h3132333435363738;
  logic        sys_clk, cmd_valid, cmd_last, cmd_ready, rsp_ready, rsp_valid;
  logic        rsp_last, code_blocked;
  logic        reset = 1'b1;
  logic [7:0]  cmd_byte, rsp_byte;
  logic [7:0]  rnd = 8'h00;
  logic [31:0] seed = 32'h77E5;
  int          failures = 0, compares = 0, cyc = 0, tries, sel, ptr;
  apdu_terminal i_apdu_terminal (.sys_clk(sys_clk), .rnd(rnd), .cmd_ready(cmd_ready),
    .rsp_valid(rsp_valid), .rsp_byte(rsp_byte), .rsp_last(rsp_last), .cmd_valid(cmd_valid),
    .cmd_byte(cmd_byte), .cmd_last(cmd_last), .rsp_ready(rsp_ready));
  card_apdu_status_responder #(.PIN_CODE(PIN), .PUK_CODE(PUK)) i_card_apdu_status_responder (
    .sys_clk(sys_clk), .reset(reset), .cmd_valid(cmd_valid), .cmd_byte(cmd_byte),
    .cmd_last(cmd_last), .cmd_ready(cmd_ready), .rsp_ready(rsp_ready),
    .rsp_valid(rsp_valid), .rsp_byte(rsp_byte), .rsp_last(rsp_last),
    .code_blocked(code_blocked));
  function automatic logic [31:0] xs(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction : xs
  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    seed <= xs(seed);
    rnd <= seed[7:0];
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      failures++;
      test_done();
    end
  end
  task automatic test_done();
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : test_done
  task automatic do_reset();
    @(posedge sys_clk);
    #1 reset = 1'b1;
    repeat (5) @(posedge sys_clk);
    #1 reset = 1'b0;
    tries = 3;
    sel = 0;
    ptr = 0;
  endtask : do_reset
  task automatic model(input logic [7:0] c[$], output int n, output logic [15:0] sw);
    int          le;
    logic [63:0] b;
    n = 0;
    sw = SW_OK;
    le = -1;
    b = '0;
    if (c.size() == 5) le = c[4];
    if (c.size() > 5 && c.size() == 6 + c[4]) le = c[c.size() - 1];
    if (le == 0) le = 256;
    for (int i = 5; i < 13 && i < c.size(); i++) b = {b[55:0], c[i]};
    if (c.size() < 4) sw = SW_WRONG_LEN;
    else if (c[0][7:4] != CLA_HI_BASIC && c[0][7:4] != CLA_HI_PROP) sw = SW_CLA_NS;
    else if (c[0][3:2] != 2'h0) sw = SW_SM_NS;
    else if (c[0][1:0] != 2'h0) sw = SW_LCH_NS;
    else case (c[1])
      INS_SELECT: if (c[2] == P1_BY_NAME) begin
          sel = 1;
          if (c[3] == P2_FCP && le > 0) n = (le < 16) ? le : 16;
        end else if (c[4] != LC_FID) sw = SW_WRONG_LEN;
        else begin
          case ({c[5], c[6]})
            FID_ROOT: sel = 1;
            16'h6F07: sel = 2;
            16'h6FB7: sel = 3;
            default: sw = SW_FILE_NF;
          endcase
          if (sw == SW_OK) ptr = 0;
          if (sw == SW_OK && c[3] == P2_FCP && le > 0) n = (le < 16) ? le : 16;
        end
      INS_STATUS: if (le > 0) n = (le < 16) ? le : 16;
      INS_READ_BIN: if (c[2][SFI_BIT]) sw = SW_NO_EF;
        else if (sel == 3) sw = SW_INCOMPAT;
        else if (sel != 2) sw = SW_NO_EF;
        else if ({c[2][0], c[3]} >= 9) sw = SW_WRONG_P1P2;
        else if (le > 0) n = (le < 9 - {c[2][0], c[3]}) ? le : 9 - {c[2][0], c[3]};
      INS_READ_REC: if (sel != 3) sw = (sel == 2) ? SW_INCOMPAT : SW_NO_EF;
        else if (c[3][2:0] == REC_NEXT && ptr >= 1) sw = SW_REC_NF;
        else if (c[3][2:0] == REC_NEXT) begin
          ptr++;
          n = 4;
        end else if (c[3][2:0] == REC_PREV) begin
          if (ptr <= 1) sw = SW_REC_NF;
        end else if (c[3][2:0] != REC_ABS) sw = SW_WRONG_P1P2;
        else if (c[2] == 8'h00 || c[2] > 8'h01) sw = SW_REC_NF;
        else n = 4;
      INS_VERIFY: if (tries == 0) sw = SW_BLOCKED;
        else if (b == PIN) tries = 3;
        else begin
          tries--;
          sw = {SW1_VERIFY, SW2_CNT_HI, 4'(tries)};
        end
      INS_UNBLOCK: if (b == PUK) tries = 3;
        else sw = SW_SEC_NS;
      INS_GET_RSP: sw = SW_TECH;
      default: sw = SW_INS_NS;
    endcase
  endtask : model
  task automatic run(input string s);
    logic [7:0]  c[$];
    logic [7:0]  v;
    logic [15:0] sw;
    int          n;
    for (int i = 0; i < s.len(); i += 2) begin
      void'($sscanf(s.substr(i, i + 1), "%h", v));
      c.push_back(v);
    end
    model(c, n, sw);
    i_apdu_terminal.xfer(c);
    `CHK(i_apdu_terminal.got.size(), n + 2, s)
    for (int i = 0; i < n; i++) `CHK(i_apdu_terminal.got[i], FILL_BYTE, s)
    `CHK({i_apdu_terminal.got[n], i_apdu_terminal.got[n + 1]}, sw, s)
    `CHK(code_blocked, (tries == 0), s)
  endtask : run
  initial begin
    do_reset();
    run("00A40004023F0000");
    run("00A4000C023F00");
    run("80F2000000");
    run("80F2000C");
    run("00A400");
    run("002000010831323334FFFFFFFF");
    run("00A4040C07F0010203040506");
    run("00B0000001");
    run("00A4000C026F07");
    run("00B0000F01");
    run("00B0000600");
    run("00B0810001");
    run("00A4000C026FB7");
    run("00B2000304");
    run("00B2000204");
    run("00B2000204");
    run("00B2000104");
    run("00B2010404");
    run("00B2020404");
    run("00B0000001");
    run("00A4000C016F");
    repeat (4) run("00200001083132333400000000");
    run("002C0001083132333400000000");
    run("002C0001083132333435363738");
    run("00200001083132333400000000");
    run("006F000000");
    run("00C0000000");
    run("30C0000000");
    run("81F2000000");
    run("84F2000002");
    do_reset();
    run("00A40004021234");
    run("00A40004023F0005");
    test_done();
  end
endmodule : tb
bind card_apdu_status_responder apdu_resp_props i_apdu_resp_props (
  .sys_clk(sys_clk), .reset(reset), .cmd_valid(cmd_valid), .cmd_byte(cmd_byte),
  .cmd_last(cmd_last), .cmd_ready(cmd_ready), .rsp_ready(rsp_ready),
  .rsp_valid(rsp_valid), .rsp_byte(rsp_byte), .rsp_last(rsp_last),
  .code_blocked(code_blocked));
`default_nettype wire
